// *** logic/adc_seq_ctrl.sv ***
// Purpose: Sequencing control of a 10-bit SAR converter with register bus
// Assumes: Single 125 MHz clock; inputs synchronous; Avalon-MM slave
// Notes:   Analog core is external; result arrives on I_SAR_RESULT
//
// Design decision made here: the Avalon-MM register port.
module adc_seq_ctrl
  import adc_seq_pkg::*;
(
  input  wire logic        I_CORE_CLK,
  input  wire logic        I_RST_N,
  input  wire logic [9:0]  I_AVS_ADDRESS,
  input  wire logic        I_AVS_READ,
  input  wire logic        I_AVS_WRITE,
  input  wire logic [31:0] I_AVS_WRITEDATA,
  input  wire logic [3:0]  I_AVS_BYTEENABLE,
  output logic [31:0]      O_AVS_READDATA,
  output logic             O_AVS_WAITREQUEST,
  input  wire logic        I_SLEEP,
  input  wire logic [3:0]  I_CAPCOMP_MODE,
  input  wire logic        I_SPECIAL_TRIG,
  input  wire logic [9:0]  I_SAR_RESULT,
  output logic             O_CONV_ACTIVE,
  output logic [3:0]       O_CHANNEL,
  output logic             O_REF_SELECT,
  output logic [11:0]      O_ANALOG_PINS,
  output logic             O_CONV_CLK_TICK,
  output logic             O_WAKE,
  output logic             O_IRQ_VECTOR,
  output logic             O_TIMER_CLEAR,
  output logic             O_IRQ
);

  logic [7:0]  ctrl_r;
  logic [7:0]  pflg_r;
  logic [7:0]  pena_r;
  logic [7:0]  ansel_lo_r;
  logic [3:0]  ansel_hi_r;
  logic [2:0]  clk_sel_r;
  logic [1:0]  sys_r;
  logic [2:0]  ev_stat_r;
  logic [2:0]  ev_mask_r;
  logic [7:0]  res_hi_r;
  logic [7:0]  res_lo_r;
  logic [15:0] timer_r;
  logic        ack_r;
  conv_state_e state_r;
  logic [7:0]  div_cnt_r;
  logic [7:0]  div_max;
  logic [3:0]  tad_cnt_r;
  logic [3:0]  dly_cnt_r;
  logic        tick;
  logic        rc_sel;
  logic        sw_start;
  logic        trig_start;
  logic        done;
  logic        abort;
  logic        rc_off;
  logic        irq_en;
  logic        wr_hit;
  logic [7:0]  idx;
  logic [7:0]  wd;
  logic        cl_en;

  assign idx    = I_AVS_ADDRESS[9:2];
  assign wd     = I_AVS_WRITEDATA[7:0];
  assign cl_en  = I_AVS_BYTEENABLE[0];
  // One-wait-state slave: write takes effect on the ack edge
  assign wr_hit = I_AVS_WRITE & ack_r & cl_en;
  assign rc_sel = (clk_sel_r[1:0] == CLKSEL_RC_LOW);
  assign irq_en = pena_r[PENA_DONE_BIT] & sys_r[SYS_PER_BIT];

  // Conversion clock divider, terminal count is one less than the tick period in core cycles
  always_comb begin
    case (clk_sel_r)
      3'h0:    div_max = 8'h00;
      3'h1:    div_max = 8'h03;
      3'h2:    div_max = 8'h0F;
      3'h4:    div_max = 8'h01;
      3'h5:    div_max = 8'h07;
      3'h6:    div_max = 8'h1F;
      default: div_max = 8'(RC_DIV_CYCLES - 1); // RC oscillator stand-in
    endcase
  end

  // Software and trigger start requests
  assign sw_start   = wr_hit & (idx == IDX_CTRL_MAIN) & wd[CTRL_BUSY_BIT]
                      & ~ctrl_r[CTRL_BUSY_BIT];
  assign trig_start = I_SPECIAL_TRIG & (I_CAPCOMP_MODE == CAPCOMP_TRIG_MODE)
                      & ctrl_r[CTRL_ENABLE_BIT];
  assign tick  = (div_cnt_r == div_max);
  assign done  = (state_r == ST_CONV) & tick
                 & (tad_cnt_r == 4'(CONV_TAD_COUNT - 1));
  // Sleep kills a non-RC conversion; clock would stop anyway
  assign abort = I_SLEEP & ~rc_sel & (state_r != ST_OFF)
                 & (state_r != ST_RCOFF);
  assign rc_off = done & I_SLEEP & ~irq_en;

  // Bus handshake: one wait state per access
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (I_AVS_READ | I_AVS_WRITE) & ~ack_r;
    end
  end

  // Main control register with busy bit managed by hardware
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      ctrl_r <= RST_CTRL_MAIN;
    end else begin
      if (wr_hit && idx == IDX_CTRL_MAIN) begin
        ctrl_r[7:2] <= wd[7:2];
        ctrl_r[CTRL_ENABLE_BIT] <= wd[CTRL_ENABLE_BIT];
      end
      // Start sets busy; done, abort or a write clearing enable clears it (clear wins over start)
      if (done || abort || (wr_hit && idx == IDX_CTRL_MAIN
          && !wd[CTRL_ENABLE_BIT])) begin
        ctrl_r[CTRL_BUSY_BIT] <= 1'b0;
      end else if ((sw_start && ctrl_r[CTRL_ENABLE_BIT]) || trig_start) begin
        ctrl_r[CTRL_BUSY_BIT] <= 1'b1;
      end
    end
  end

  // Plain configuration registers
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      pena_r     <= RST_PENA;
      ansel_lo_r <= RST_ANSEL_LOW;
      ansel_hi_r <= RST_ANSEL_HIGH;
      clk_sel_r  <= RST_CLK_SEL;
      sys_r      <= 2'h0;
      ev_mask_r  <= 3'h0;
    end else if (wr_hit) begin
      case (idx)
        IDX_PERIPH_ENA:  pena_r     <= wd;
        IDX_ANSEL_LOW:   ansel_lo_r <= wd;
        IDX_ANSEL_HIGH:  ansel_hi_r <= wd[3:0];
        IDX_CLK_CTRL:    clk_sel_r  <= wd[CLKSEL_LSB +: 3];
        IDX_SYS_CTRL:    sys_r      <= wd[1:0];
        IDX_IRQ_MASK:    ev_mask_r  <= wd[2:0];
        default: ;
      endcase
    end
  end

  // Peripheral flag register; hardware set beats software write
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      pflg_r <= RST_PFLAG;
    end else begin
      if (wr_hit && idx == IDX_PERIPH_FLG) begin
        pflg_r <= wd;
      end
      if (done) begin
        pflg_r[PFLAG_DONE_BIT] <= 1'b1;
      end
    end
  end

  // Sticky event status, write one to clear, set wins
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      ev_stat_r <= 3'h0;
    end else begin
      ev_stat_r <= (ev_stat_r & ~((wr_hit && idx == IDX_IRQ_STATUS) ?
                    wd[2:0] : 3'h0))
                   | {abort, done & I_SLEEP & irq_en, done};
    end
  end

  // Result registers hold across reset: no reset branch
  always_ff @(posedge I_CORE_CLK) begin
    if (done) begin
      if (ctrl_r[CTRL_JUSTIFY_BIT]) begin
        res_hi_r <= {6'h00, I_SAR_RESULT[9:8]};
        res_lo_r <= I_SAR_RESULT[7:0];
      end else begin
        res_hi_r <= I_SAR_RESULT[9:2];
        res_lo_r <= {I_SAR_RESULT[1:0], 6'h00};
      end
    end
  end

  // Companion timer, cleared by every special event trigger
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      timer_r       <= 16'h0000;
      O_TIMER_CLEAR <= 1'b0;
    end else begin
      O_TIMER_CLEAR <= I_SPECIAL_TRIG
                       & (I_CAPCOMP_MODE == CAPCOMP_TRIG_MODE);
      if (I_SPECIAL_TRIG && I_CAPCOMP_MODE == CAPCOMP_TRIG_MODE) begin
        timer_r <= 16'h0000;
      end else begin
        timer_r <= timer_r + 16'h0001;
      end
    end
  end

  // Conversion sequencer
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      state_r   <= ST_OFF;
      div_cnt_r <= 8'h00;
      tad_cnt_r <= 4'h0;
      dly_cnt_r <= 4'h0;
    end else begin
      div_cnt_r <= tick ? 8'h00 : div_cnt_r + 8'h01;
      case (state_r)
        ST_OFF: begin
          if (ctrl_r[CTRL_ENABLE_BIT] && !I_SLEEP) state_r <= ST_IDLE;
        end
        ST_IDLE: begin
          tad_cnt_r <= 4'h0;
          dly_cnt_r <= 4'h0;
          if (!ctrl_r[CTRL_ENABLE_BIT]) state_r <= ST_OFF;
          else if (abort) state_r <= ST_RCOFF;
          else if (ctrl_r[CTRL_BUSY_BIT])
            state_r <= rc_sel ? ST_DELAY : ST_CONV;
        end
        ST_DELAY: begin
          dly_cnt_r <= dly_cnt_r + 4'h1;
          if (abort) state_r <= ST_RCOFF;
          else if (dly_cnt_r == 4'(INSTR_CYCLES - 1)) begin
            state_r   <= ST_CONV;
            div_cnt_r <= 8'h00;
          end
        end
        ST_CONV: begin
          if (tick) tad_cnt_r <= tad_cnt_r + 4'h1;
          if (abort) state_r <= ST_RCOFF;
          else if (!ctrl_r[CTRL_ENABLE_BIT]) state_r <= ST_OFF;
          else if (rc_off) state_r <= ST_RCOFF;
          else if (done) state_r <= ST_IDLE;
        end
        ST_RCOFF: begin
          // Module off, enable bit still set; wakes on exit from sleep
          if (!I_SLEEP || !ctrl_r[CTRL_ENABLE_BIT]) state_r <= ST_OFF;
        end
        default: state_r <= ST_OFF;
      endcase
    end
  end

  // Registered outputs toward core and analog side
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_CONV_ACTIVE   <= 1'b0;
      O_CHANNEL       <= 4'h0;
      O_REF_SELECT    <= 1'b0;
      O_ANALOG_PINS   <= {RST_ANSEL_HIGH, RST_ANSEL_LOW};
      O_CONV_CLK_TICK <= 1'b0;
      O_WAKE          <= 1'b0;
      O_IRQ_VECTOR    <= 1'b0;
      O_IRQ           <= 1'b0;
    end else begin
      O_CONV_ACTIVE   <= (state_r == ST_CONV) & ~done & ~abort;
      O_CHANNEL       <= ctrl_r[5:2];
      O_REF_SELECT    <= ctrl_r[6];
      O_ANALOG_PINS   <= {ansel_hi_r, ansel_lo_r};
      O_CONV_CLK_TICK <= tick & (state_r == ST_CONV);
      O_WAKE          <= done & I_SLEEP & irq_en;
      O_IRQ_VECTOR    <= done & I_SLEEP & irq_en & sys_r[SYS_GLB_BIT];
      O_IRQ           <= |(ev_stat_r & ev_mask_r);
    end
  end

  // Read data and waitrequest; unmapped reads return zero
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_AVS_READDATA    <= 32'h0000_0000;
      O_AVS_WAITREQUEST <= 1'b1;
    end else begin
      O_AVS_WAITREQUEST <= ~((I_AVS_READ | I_AVS_WRITE) & ~ack_r);
      case (idx)
        IDX_PERIPH_FLG:  O_AVS_READDATA <= {24'h0, pflg_r};
        IDX_RES_HIGH:    O_AVS_READDATA <= {24'h0, res_hi_r};
        IDX_CTRL_MAIN:   O_AVS_READDATA <= {24'h0, ctrl_r};
        IDX_PERIPH_ENA:  O_AVS_READDATA <= {24'h0, pena_r};
        IDX_ANSEL_LOW:   O_AVS_READDATA <= {24'h0, ansel_lo_r};
        IDX_ANSEL_HIGH:  O_AVS_READDATA <= {28'h0, ansel_hi_r};
        IDX_RES_LOW:     O_AVS_READDATA <= {24'h0, res_lo_r};
        IDX_CLK_CTRL:    O_AVS_READDATA <= {25'h0, clk_sel_r, 4'h0};
        IDX_SYS_CTRL:    O_AVS_READDATA <= {30'h0, sys_r};
        IDX_IRQ_STATUS:  O_AVS_READDATA <= {29'h0, ev_stat_r};
        IDX_IRQ_MASK:    O_AVS_READDATA <= {29'h0, ev_mask_r};
        IDX_TIMER_LOW:   O_AVS_READDATA <= {24'h0, timer_r[7:0]};
        IDX_TIMER_HIGH:  O_AVS_READDATA <= {24'h0, timer_r[15:8]};
        default:         O_AVS_READDATA <= 32'h0000_0000;
      endcase
    end
  end

  AST_DONE_CLEARS_BUSY: assert property (@(posedge I_CORE_CLK)
    disable iff (!I_RST_N) done |=> !ctrl_r[CTRL_BUSY_BIT])
    else $error("busy bit not cleared after completion");
  AST_DONE_SETS_FLAG: assert property (@(posedge I_CORE_CLK)
    disable iff (!I_RST_N) done |=> pflg_r[PFLAG_DONE_BIT])
    else $error("done flag not set");
  AST_RC_DELAY: assert property (@(posedge I_CORE_CLK)
    disable iff (!I_RST_N)
    (state_r == ST_IDLE && ctrl_r[CTRL_BUSY_BIT] && rc_sel && !abort
     && ctrl_r[CTRL_ENABLE_BIT]) |=> (state_r == ST_DELAY)[*4])
    else $error("RC start not delayed one instruction");
  AST_SLEEP_ABORT: assert property (@(posedge I_CORE_CLK)
    disable iff (!I_RST_N)
    abort |=> (state_r == ST_RCOFF) && !ctrl_r[CTRL_BUSY_BIT])
    else $error("sleep did not abort conversion");
  AST_ENABLE_KEPT: assert property (@(posedge I_CORE_CLK)
    disable iff (!I_RST_N)
    (rc_off && !wr_hit) |=> ctrl_r[CTRL_ENABLE_BIT])
    else $error("enable bit lost on power off");
  AST_TRIG_START: assert property (@(posedge I_CORE_CLK)
    disable iff (!I_RST_N)
    (trig_start && !done && !abort && !wr_hit) |=> ctrl_r[CTRL_BUSY_BIT])
    else $error("trigger did not start conversion");
  AST_TRIG_TIMER: assert property (@(posedge I_CORE_CLK)
    disable iff (!I_RST_N)
    (I_SPECIAL_TRIG && I_CAPCOMP_MODE == CAPCOMP_TRIG_MODE)
    |=> timer_r == 16'h0000 && O_TIMER_CLEAR)
    else $error("trigger did not clear timer");
  AST_TRIG_IGNORED: assert property (@(posedge I_CORE_CLK)
    disable iff (!I_RST_N)
    (I_SPECIAL_TRIG && !ctrl_r[CTRL_ENABLE_BIT] && !wr_hit)
    |=> !ctrl_r[CTRL_BUSY_BIT])
    else $error("trigger acted while disabled");
  AST_RIGHT_JUST: assert property (@(posedge I_CORE_CLK)
    disable iff (!I_RST_N)
    (done && ctrl_r[CTRL_JUSTIFY_BIT]) |=>
    res_lo_r == $past(I_SAR_RESULT[7:0]) && res_hi_r[7:2] == 6'h00)
    else $error("right justified result wrong");
  AST_WAKE: assert property (@(posedge I_CORE_CLK)
    disable iff (!I_RST_N)
    (done && I_SLEEP && irq_en) |=> O_WAKE)
    else $error("no wake on completion in sleep");
  AST_NO_SLEEP_RUN: assert property (@(posedge I_CORE_CLK)
    disable iff (!I_RST_N)
    (I_SLEEP && !rc_sel) |=> !O_CONV_ACTIVE)
    else $error("conversion ran in sleep without RC clock");

  COV_SW_CONV: cover property (@(posedge I_CORE_CLK)
    disable iff (!I_RST_N) sw_start ##[1:400] done);
  COV_SLEEP_WAKE: cover property (@(posedge I_CORE_CLK)
    disable iff (!I_RST_N) done && I_SLEEP && irq_en);
  COV_ABORT: cover property (@(posedge I_CORE_CLK)
    disable iff (!I_RST_N) abort);
  COV_TRIG: cover property (@(posedge I_CORE_CLK)
    disable iff (!I_RST_N) trig_start);
endmodule

// *** pkg/adc_seq_pkg.sv ***
// Purpose: Shared constants for the converter sequencing control block
// Assumes: Avalon-MM word addressing, byte address = 4 * register index
// Notes:   Register indexes match the device map; one word per register
package adc_seq_pkg;
  // Register indexes (byte address is four times the index)
  localparam logic [7:0] IDX_PERIPH_FLG  = 8'h0C;
  localparam logic [7:0] IDX_RES_HIGH    = 8'h1E;
  localparam logic [7:0] IDX_CTRL_MAIN   = 8'h1F;
  localparam logic [7:0] IDX_PERIPH_ENA  = 8'h8C;
  localparam logic [7:0] IDX_ANSEL_LOW   = 8'h91;
  localparam logic [7:0] IDX_ANSEL_HIGH  = 8'h93;
  localparam logic [7:0] IDX_RES_LOW     = 8'h9E;
  localparam logic [7:0] IDX_CLK_CTRL    = 8'h9F;
  // Own registers: system control, interrupt status/mask and timer
  localparam logic [7:0] IDX_SYS_CTRL    = 8'hA0;
  localparam logic [7:0] IDX_IRQ_STATUS  = 8'hA1;
  localparam logic [7:0] IDX_IRQ_MASK    = 8'hA2;
  localparam logic [7:0] IDX_TIMER_LOW   = 8'hA3;
  localparam logic [7:0] IDX_TIMER_HIGH  = 8'hA4;

  // Reset values
  localparam logic [7:0] RST_PFLAG       = 8'h00;
  localparam logic [7:0] RST_CTRL_MAIN   = 8'h00;
  localparam logic [7:0] RST_PENA        = 8'h00;
  localparam logic [7:0] RST_ANSEL_LOW   = 8'hFF;
  localparam logic [3:0] RST_ANSEL_HIGH  = 4'hF;
  localparam logic [2:0] RST_CLK_SEL     = 3'h0;

  // Field positions
  localparam int CTRL_JUSTIFY_BIT = 7;
  localparam int CTRL_BUSY_BIT    = 1;
  localparam int CTRL_ENABLE_BIT  = 0;
  localparam int PFLAG_DONE_BIT   = 6;
  localparam int PENA_DONE_BIT    = 6;
  localparam int CLKSEL_LSB       = 4;
  localparam int SYS_GLB_BIT      = 1;
  localparam int SYS_PER_BIT      = 0;
  // Interrupt status/mask bit positions
  localparam int EV_DONE_BIT      = 0;
  localparam int EV_WAKE_BIT      = 1;
  localparam int EV_ABORT_BIT     = 2;

  // Capture/compare mode that arms the special event trigger
  localparam logic [3:0] CAPCOMP_TRIG_MODE = 4'hB;
  localparam logic [1:0] CLKSEL_RC_LOW     = 2'h3;

  // Conversion timing
  localparam int RESULT_BITS       = 10;
  localparam int CORE_CLK_MHZ      = 125;
  localparam int INSTR_CYCLE_NS    = 32;
  localparam int CORE_PERIOD_NS    = 8;
  localparam int INSTR_CYCLES      =
    (INSTR_CYCLE_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  // Conversion spans 12 conversion-clock periods
  localparam int CONV_TAD_COUNT    = 12;
  localparam int RC_DIV_CYCLES     = 250;
  localparam logic [3:0] WAIT_DEPTH = 4'h1;

  typedef enum logic [2:0] {
    ST_OFF    = 3'b000,
    ST_IDLE   = 3'b001,
    ST_DELAY  = 3'b010,
    ST_CONV   = 3'b011,
    ST_RCOFF  = 3'b100
  } conv_state_e;
endpackage

// *** verif/ccp_sar_model.sv ***
// Purpose: Far-side stand-in for the trigger unit and the analog core
// Assumes: Requests come from the bench on rising edges
// Notes:   Result lines scramble once no conversion can be sampling them
module ccp_sar_model (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       conv_active,
  input  wire logic       trig_req,
  input  wire logic [3:0] mode_in,
  input  wire logic [9:0] value,
  output logic [3:0]      mode,
  output logic            trig,
  output logic [9:0]      sar
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       req_d_r;
  logic [1:0] idle_r;
  // One trigger pulse per request; bench selects channel and waits first
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      req_d_r <= 1'h0;
      trig    <= 1'h0;
    end else begin
      req_d_r <= trig_req;
      trig    <= trig_req & ~req_d_r;
    end
  end
  // Idle count; a stale result must not look valid
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idle_r <= 2'h0;
    end else if (conv_active) begin
      idle_r <= 2'h0;
    end else if (idle_r != 2'h3) begin
      idle_r <= idle_r + 2'h1;
    end
  end
  // Mode passes straight through from the bench
  assign mode = mode_in;
  assign sar  = (idle_r == 2'h3) ? ~value : value;
endmodule

// *** verif/tb_top.sv ***
// Purpose: Self-checking bench for the converter sequencing control
// Assumes: Avalon master with one wait state slave, 125 MHz clock
// Notes:   Result values random from a fixed seed, corners 000 and 3FF
module tb_top
  import adc_seq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int ACQ_CYCLES = 16; // Sampling wait, plain default
  logic        clk = 1'h0;
  logic        rst_n = 1'h0;
  logic [9:0]  addr = 10'h000;
  logic        rd = 1'h0;
  logic        wr = 1'h0;
  logic [31:0] wdata = 32'h0;
  logic        sleep = 1'h0;
  logic        trig_req = 1'h0;
  logic [3:0]  mode_in = 4'h0;
  logic [9:0]  value = 10'h000;
  logic [3:0]  be = 4'hF;
  logic [31:0] rdata, gap = 32'h0, tcnt = 32'h0;
  logic        waitreq, trig, conv, tick, wake, vec, tclr, irq, ref_sel;
  logic [3:0]  mode, chan;
  logic [9:0]  sar;
  logic [11:0] pins;
  logic [7:0]  rd_q;
  int          num_errors = 0;
  int          num_checks = 0;
  // Free-running core clock
  always #4 clk = ~clk;
  adc_seq_ctrl dut (.I_CORE_CLK(clk), .I_RST_N(rst_n),
    .I_AVS_ADDRESS(addr), .I_AVS_READ(rd), .I_AVS_WRITE(wr),
    .I_AVS_WRITEDATA(wdata), .I_AVS_BYTEENABLE(be),
    .O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(waitreq),
    .I_SLEEP(sleep), .I_CAPCOMP_MODE(mode), .I_SPECIAL_TRIG(trig),
    .I_SAR_RESULT(sar), .O_CONV_ACTIVE(conv), .O_CHANNEL(chan),
    .O_REF_SELECT(ref_sel), .O_ANALOG_PINS(pins),
    .O_CONV_CLK_TICK(tick), .O_WAKE(wake), .O_IRQ_VECTOR(vec),
    .O_TIMER_CLEAR(tclr), .O_IRQ(irq));
  ccp_sar_model partner (.clk(clk), .rst_n(rst_n), .conv_active(conv),
    .trig_req(trig_req), .mode_in(mode_in), .value(value),
    .mode(mode), .trig(trig), .sar(sar));
  // Spacing of conversion clock ticks, last gap kept
  always @(posedge clk) begin
    if (tick === 1'h1) begin
      gap  <= tcnt;
      tcnt <= 32'h1;
    end else begin
      tcnt <= tcnt + 32'h1;
    end
  end
  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Hold the request until waitrequest is sampled low
  task automatic bus(input logic we, input logic [7:0] idx,
                     input logic [7:0] d);
    int n;
    n = 0;
    addr  <= {idx, 2'h0};
    wdata <= {24'h0, d};
    rd    <= ~we;
    wr    <= we;
    do begin
      @(posedge clk);
      n++;
    end while (waitreq !== 1'h0 && n < 50);
    rd_q = rdata[7:0];
    if (n >= 50) check("bus_wait", 32'h1, 32'h0);
    rd <= 1'h0;
    wr <= 1'h0;
    @(posedge clk);
  endtask
  task automatic wr_reg(input logic [7:0] idx, input logic [7:0] d);
    bus(1'h1, idx, d);
  endtask
  task automatic rd_chk(input string nm, input logic [7:0] idx,
                        input logic [7:0] e);
    bus(1'h0, idx, 8'h00);
    check(nm, rd_q, e);
  endtask
  // Poll the busy bit, bounded
  task automatic wait_done();
    int n;
    n = 0;
    do begin
      bus(1'h0, IDX_CTRL_MAIN, 8'h00);
      n++;
    end while (rd_q[CTRL_BUSY_BIT] !== 1'h0 && n < 3000);
    if (n >= 3000) check("busy_wait", 32'h1, 32'h0);
  endtask
  // Expected high and low bytes for a result
  function automatic logic [15:0] split(logic [9:0] r, logic right);
    return right ? {6'h00, r} : {r, 6'h00};
  endfunction
  function automatic logic [31:0] tick_gap(logic [2:0] cs);
    case (cs)
      3'h0: return 32'h1;
      3'h1: return 32'h4;
      3'h2: return 32'h10;
      3'h4: return 32'h2;
      3'h5: return 32'h8;
      3'h6: return 32'h20;
      default: return RC_DIV_CYCLES;
    endcase
  endfunction
  task automatic convert(input logic [2:0] cs, input logic right,
                         input logic [3:0] ch, input logic [9:0] r,
                         input logic msk);
    logic [15:0] e;
    e = split(r, right);
    value <= r;
    wr_reg(IDX_PERIPH_FLG, 8'h00);
    wr_reg(IDX_IRQ_STATUS, 8'h07);
    wr_reg(IDX_IRQ_MASK, {7'h00, msk});
    wr_reg(IDX_CLK_CTRL, {1'h0, cs, 4'h0});
    rd_chk("clk_sel", IDX_CLK_CTRL, {1'h0, cs, 4'h0});
    wr_reg(IDX_CTRL_MAIN, {right, msk, ch, 2'h1});
    repeat (ACQ_CYCLES) @(posedge clk);
    wr_reg(IDX_CTRL_MAIN, {right, msk, ch, 2'h3});
    wait_done();
    check("ctrl_done", rd_q, {right, msk, ch, 2'h1});
    check("chan", chan, {28'h0, ch});
    check("ref_sel", ref_sel, {31'h0, msk});
    check("tick_gap", gap, tick_gap(cs));
    rd_chk("res_high", IDX_RES_HIGH, e[15:8]);
    rd_chk("res_low", IDX_RES_LOW, e[7:0]);
    rd_chk("done_flag", IDX_PERIPH_FLG, 8'h40);
    check("irq_on", irq, {31'h0, msk});
    wr_reg(IDX_IRQ_STATUS, 8'h01);
    @(posedge clk);
    check("irq_off", irq, 32'h0);
    rd_chk("status_clr", IDX_IRQ_STATUS, 8'h00);
  endtask
  // Special event trigger with the converter on or off
  task automatic fire(input logic en);
    bit seen;
    seen = 1'b0;
    mode_in <= CAPCOMP_TRIG_MODE;
    wr_reg(IDX_CLK_CTRL, 8'h30);
    wr_reg(IDX_CTRL_MAIN, {7'h00, en});
    repeat (ACQ_CYCLES) @(posedge clk);
    trig_req <= 1'h1;
    repeat (5) begin
      @(posedge clk);
      trig_req <= 1'h0;
      if (tclr === 1'h1) seen = 1'b1;
    end
    check("timer_clear", seen, 32'h1);
    rd_chk("trig_busy", IDX_CTRL_MAIN, {6'h00, en, en});
    if (en) wait_done();
  endtask
  // RC conversion across sleep, with and without wake
  task automatic sleep_rc(input logic [7:0] pie, input logic [7:0] sys);
    int n;
    bit woke, vecd;
    woke = 1'b0;
    vecd = 1'b0;
    value <= 10'($urandom());
    wr_reg(IDX_PERIPH_ENA, pie);
    wr_reg(IDX_SYS_CTRL, sys);
    wr_reg(IDX_CLK_CTRL, 8'h70);
    wr_reg(IDX_CTRL_MAIN, 8'h81);
    repeat (ACQ_CYCLES) @(posedge clk);
    wr_reg(IDX_CTRL_MAIN, 8'h83);
    sleep <= 1'h1;
    for (n = 0; n < 9000 && !(n > 100 && conv === 1'h0); n++) begin
      @(posedge clk);
      if (wake === 1'h1) woke = 1'b1;
      if (vec === 1'h1) vecd = 1'b1;
    end
    check("wake", woke, {31'h0, pie[6]});
    check("vector", vecd, {31'h0, pie[6] & sys[1]});
    sleep <= 1'h0;
    rd_chk("ctrl_sleep", IDX_CTRL_MAIN, 8'h81);
    rd_chk("res_low_sl", IDX_RES_LOW, value[7:0]);
    $display("test sleep_rc pie %h sys %h done", pie, sys);
  endtask
  task automatic reset_chk();
    rd_chk("pflag", IDX_PERIPH_FLG, RST_PFLAG);
    rd_chk("ctrl", IDX_CTRL_MAIN, RST_CTRL_MAIN);
    rd_chk("pena", IDX_PERIPH_ENA, RST_PENA);
    rd_chk("ansel_lo", IDX_ANSEL_LOW, RST_ANSEL_LOW);
    rd_chk("ansel_hi", IDX_ANSEL_HIGH, {4'h0, RST_ANSEL_HIGH});
    rd_chk("clk_ctrl", IDX_CLK_CTRL, {1'h0, RST_CLK_SEL, 4'h0});
    check("pins", pins, 32'hFFF);
    check("active", conv, 32'h0);
    wr_reg(8'h50, 8'hA5);
    rd_chk("unmapped", 8'h50, 8'h00);
    // Write without the low byte lane must be dropped
    be <= 4'hE;
    wr_reg(IDX_ANSEL_LOW, 8'h00);
    be <= 4'hF;
    rd_chk("be_off", IDX_ANSEL_LOW, RST_ANSEL_LOW);
    wr_reg(IDX_ANSEL_HIGH, 8'hF5);
    rd_chk("ansel_hi_w", IDX_ANSEL_HIGH, 8'h05);
    check("pins_w", pins, 32'h5FF);
    $display("test reset_values done");
  endtask
  // Watchdog for anything that hangs
  initial begin
    repeat (100000) @(posedge clk);
    num_errors++;
    $display("ERROR watchdog expected 0 seen 1");
    finish_test();
  end
  initial begin
    logic [2:0] codes [8];
    logic [9:0] r, keep;
    int i;
    codes = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6, 3'h3, 3'h7};
    r = 10'($urandom(32'h7E0D));
    repeat (20) @(posedge clk);
    rst_n <= 1'h1;
    reset_chk();
    for (i = 0; i < 8; i++) begin
      r = (i == 0) ? 10'h000 : (i == 1) ? 10'h3FF : 10'($urandom());
      convert(codes[i], i[0], 4'($urandom() % 12), r, i[1]);
    end
    $display("test conversions done");
    fire(1'h0);
    fire(1'h1);
    $display("test trigger done");
    // Sleep on a divided clock aborts the conversion
    wr_reg(IDX_IRQ_STATUS, 8'h07);
    wr_reg(IDX_CLK_CTRL, 8'h60);
    wr_reg(IDX_CTRL_MAIN, 8'h03);
    sleep <= 1'h1;
    repeat (8) @(posedge clk);
    check("abort_active", conv, 32'h0);
    rd_chk("abort_ctrl", IDX_CTRL_MAIN, 8'h01);
    rd_chk("abort_stat", IDX_IRQ_STATUS, 8'h04);
    sleep <= 1'h0;
    $display("test sleep_abort done");
    sleep_rc(8'h40, 8'h03);
    sleep_rc(8'h40, 8'h01);
    sleep_rc(8'h00, 8'h01);
    // Reset in mid-conversion leaves the results alone
    keep = value;
    value <= ~keep;
    wr_reg(IDX_CLK_CTRL, 8'h60);
    wr_reg(IDX_CTRL_MAIN, 8'h83);
    repeat (50) @(posedge clk);
    rst_n <= 1'h0;
    repeat (3) @(posedge clk);
    rst_n <= 1'h1;
    reset_chk();
    rd_chk("keep_high", IDX_RES_HIGH, {6'h00, keep[9:8]});
    rd_chk("keep_low", IDX_RES_LOW, keep[7:0]);
    $display("test mid_reset done");
    finish_test();
  end
endmodule
